// ==== arp_pkg.sv ====
// Constants and types for the alias remap, parity and status register slice.
// Function
// - Alias holds 7-bit address, bit0 reserved
// - Respond when target matches nonzero alias
// - Replace address with paired remote target
// - Zero alias disables its slot
// - Slots five to seven at 0x15-0x17
// - Threshold 16 bits, 0x18/0x19, reset 0x0100
// - Parity errors never raise count past programmed threshold
// - Count forward parity errors, 0x1a/0x1b
// - Status bit2 set after any parity error
// - Status bit1 reports serial input detected
// - Status bit0 reports receiver lock
// - Remote target supplies substituted 7-bit address
package arp_pkg;

    localparam int ARP_SLOTS = 3;
    localparam int ARP_FIRST_SLOT = 5;

    localparam logic [7:0] ARP_OFS_ALIAS5 = 8'h15;
    localparam logic [7:0] ARP_OFS_ALIAS6 = 8'h16;
    localparam logic [7:0] ARP_OFS_ALIAS7 = 8'h17;
    localparam logic [7:0] ARP_OFS_LIMIT_LO = 8'h18;
    localparam logic [7:0] ARP_OFS_LIMIT_HI = 8'h19;
    localparam logic [7:0] ARP_OFS_COUNT_LO = 8'h1a;
    localparam logic [7:0] ARP_OFS_COUNT_HI = 8'h1b;
    localparam logic [7:0] ARP_OFS_STATUS = 8'h1c;

    localparam logic [7:0] ARP_RST_ALIAS = 8'h00;
    localparam logic [15:0] ARP_RST_LIMIT = 16'h0100;
    localparam logic [15:0] ARP_RST_COUNT = 16'h0000;

    localparam int ARP_ALIAS_MSB = 7;
    localparam int ARP_ALIAS_LSB = 1;
    localparam int ARP_ST_LOCK = 0;
    localparam int ARP_ST_SIGDET = 1;
    localparam int ARP_ST_PERR = 2;
    localparam int ARP_ST_RESERVED_BIT = 3;
    localparam int ARP_ST_REV_LSB = 4;

    // Arbitrary neutral value; not tied to any real part.
    localparam logic [3:0] ARP_SILICON_REVISION = 4'h0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } arp_reg_req_s;

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
    } arp_txn_s;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [6:0] addr;
    } arp_fwd_s;

    typedef struct packed {
        logic [ARP_SLOTS-1:0][7:0] alias_slot;
        logic [15:0] limit;
        logic [15:0] count;
        logic perr;
        logic [7:0] rdata;
        arp_fwd_s fwd;
    } arp_state_s;

endpackage

// ==== arp_regs.sv ====
// Alias remap slots five to seven, parity error limit and count, and link status.
`timescale 1ns/1ps
module arp_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register access from the control-bus slave
    input arp_pkg::arp_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Local control-bus transaction in, remapped transaction out
    input arp_pkg::arp_txn_s txn,
    output arp_pkg::arp_fwd_s fwd,
    // Paired remote target addresses held outside this slice
    input wire logic [6:0] remote_target_five,
    input wire logic [6:0] remote_target_six,
    input wire logic [6:0] remote_target_seven,
    // Link condition
    input wire logic parity_error,
    input wire logic signal_detect,
    input wire logic link_lock
);

    arp_pkg::arp_state_s state;
    arp_pkg::arp_state_s next_state;
    logic [arp_pkg::ARP_SLOTS-1:0] slot_hit;
    logic [arp_pkg::ARP_SLOTS-1:0][6:0] target;

    assign target[0] = remote_target_five;
    assign target[1] = remote_target_six;
    assign target[2] = remote_target_seven;

    genvar g;
    generate
        for (g = 0; g < arp_pkg::ARP_SLOTS; g++) begin : g_slot
            assign slot_hit[g] = (state.alias_slot[g][arp_pkg::ARP_ALIAS_MSB:arp_pkg::ARP_ALIAS_LSB] != 7'h00)
                && (state.alias_slot[g][arp_pkg::ARP_ALIAS_MSB:arp_pkg::ARP_ALIAS_LSB] == txn.addr);
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.fwd.valid = txn.valid;
        next_state.fwd.hit = 1'b0;
        next_state.fwd.addr = 7'h00;
        for (int i = arp_pkg::ARP_SLOTS - 1; i >= 0; i--) begin
            if (txn.valid && slot_hit[i]) begin
                next_state.fwd.hit = 1'b1;
                next_state.fwd.addr = target[i];
            end
        end

        if (reg_req.wr) begin
            case (reg_req.addr)
                // alias storage, bit 0 kept clear
                arp_pkg::ARP_OFS_ALIAS5: next_state.alias_slot[0] = {reg_req.wdata[7:1], 1'b0};
                arp_pkg::ARP_OFS_ALIAS6: next_state.alias_slot[1] = {reg_req.wdata[7:1], 1'b0};
                arp_pkg::ARP_OFS_ALIAS7: next_state.alias_slot[2] = {reg_req.wdata[7:1], 1'b0};
                arp_pkg::ARP_OFS_LIMIT_LO: next_state.limit[7:0] = reg_req.wdata;
                arp_pkg::ARP_OFS_LIMIT_HI: next_state.limit[15:8] = reg_req.wdata;
                arp_pkg::ARP_OFS_COUNT_LO: next_state.count[7:0] = reg_req.wdata;
                arp_pkg::ARP_OFS_COUNT_HI: next_state.count[15:8] = reg_req.wdata;
                default: begin
                end
            endcase
            // Clearing the count to zero also clears the parity error flag.
            if ((reg_req.addr == arp_pkg::ARP_OFS_COUNT_LO || reg_req.addr == arp_pkg::ARP_OFS_COUNT_HI)
                && next_state.count == 16'h0000) begin
                next_state.perr = 1'b0;
            end
        end

        if (parity_error && next_state.count < next_state.limit) begin
            next_state.count = next_state.count + 16'h0001;
        end
        // sticky flag, error wins over clear
        if (parity_error) begin
            next_state.perr = 1'b1;
        end

        next_state.rdata = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                arp_pkg::ARP_OFS_ALIAS5: next_state.rdata = state.alias_slot[0];
                arp_pkg::ARP_OFS_ALIAS6: next_state.rdata = state.alias_slot[1];
                arp_pkg::ARP_OFS_ALIAS7: next_state.rdata = state.alias_slot[2];
                arp_pkg::ARP_OFS_LIMIT_LO: next_state.rdata = state.limit[7:0];
                arp_pkg::ARP_OFS_LIMIT_HI: next_state.rdata = state.limit[15:8];
                arp_pkg::ARP_OFS_COUNT_LO: next_state.rdata = state.count[7:0];
                arp_pkg::ARP_OFS_COUNT_HI: next_state.rdata = state.count[15:8];
                arp_pkg::ARP_OFS_STATUS: begin
                    next_state.rdata[7:arp_pkg::ARP_ST_REV_LSB] = arp_pkg::ARP_SILICON_REVISION;
                    next_state.rdata[arp_pkg::ARP_ST_RESERVED_BIT] = 1'b0;
                    next_state.rdata[arp_pkg::ARP_ST_PERR] = state.perr;
                    next_state.rdata[arp_pkg::ARP_ST_SIGDET] = signal_detect;
                    next_state.rdata[arp_pkg::ARP_ST_LOCK] = link_lock;
                end
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= '0;
            for (int i = 0; i < arp_pkg::ARP_SLOTS; i++) begin
                state.alias_slot[i] <= arp_pkg::ARP_RST_ALIAS;
            end
            state.limit <= arp_pkg::ARP_RST_LIMIT;
            state.count <= arp_pkg::ARP_RST_COUNT;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign fwd = state.fwd;

endmodule

// ==== arp_regs_props.sv ====
// Assertions for the alias, parity and status slice.
`timescale 1ns/1ps
module arp_regs_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports
    input arp_pkg::arp_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input arp_pkg::arp_txn_s txn,
    input arp_pkg::arp_fwd_s fwd,
    input wire logic parity_error,
    input wire logic signal_detect,
    input wire logic link_lock
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire st = reg_req.rd && reg_req.addr == 8'h1c;
    sequence s_err_rd;
        parity_error ##1 st;
    endsequence
    chk_fwd_answer: assert property (txn.valid |=> fwd.valid) else $error("no fwd");
    chk_zero_miss: assert property (txn.valid && txn.addr == 7'h0 |=> !fwd.hit) else $error("zero hit");
    chk_miss_addr: assert property (fwd.valid && !fwd.hit |-> fwd.addr == 7'h0) else $error("miss addr");
    chk_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00) else $error("rdata");
    chk_alias_bit0: assert property (reg_req.rd && reg_req.addr inside {8'h15, 8'h16, 8'h17} |=> !reg_rdata[0])
        else $error("bit0");
    chk_status_live: assert property (st |=> !reg_rdata[3] && reg_rdata[1] == $past(signal_detect)
        && reg_rdata[0] == $past(link_lock)) else $error("status");
    chk_status_rev: assert property (st |=> reg_rdata[7:4] == arp_pkg::ARP_SILICON_REVISION) else $error("rev");
    chk_perr_set: assert property (s_err_rd |=> reg_rdata[2]) else $error("perr");
endmodule
bind arp_regs arp_regs_props i_props (.*);

// ==== arp_link_model.sv ====
// Model of the link receiver flags and remote target registers.
`timescale 1ns/1ps
module arp_link_model (
    // Clock and bench requests
    input wire logic sys_clk,
    input wire logic err_req,
    input wire logic [1:0] cond_req,
    // Far side outputs
    output logic [6:0] remote_target_five,
    output logic [6:0] remote_target_six,
    output logic [6:0] remote_target_seven,
    output logic parity_error = 1'b0,
    output logic signal_detect = 1'b0,
    output logic link_lock = 1'b0
);
    assign remote_target_five = 7'h31;
    assign remote_target_six = 7'h52;
    assign remote_target_seven = 7'h63;
    // Flags follow requests one edge late, as a receiver's registered detectors would.
    always @(posedge sys_clk) begin
        parity_error <= err_req;
        {signal_detect, link_lock} <= cond_req;
    end
endmodule

// ==== alias_remap_parity_status_regs_tb.sv ====
// Self-checking bench for the alias, parity and status slice.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module alias_remap_parity_status_regs_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic err_req = 1'b0;
    logic [1:0] cond_req = 2'b00;
    arp_pkg::arp_reg_req_s reg_req = '0;
    arp_pkg::arp_txn_s txn = '0;
    arp_pkg::arp_fwd_s fwd;
    logic [7:0] reg_rdata, d;
    logic [6:0] remote_target_five, remote_target_six, remote_target_seven, t;
    logic parity_error, signal_detect, link_lock;
    logic [6:0] al [3] = '{7'h0, 7'h0, 7'h0};
    int n_errors = 0;
    int n_compared = 0;
    arp_regs i_dut (.*);
    arp_link_model i_link (.*);
    // Slot five wins over six and seven when aliases collide.
    function automatic logic [7:0] remap(input logic [6:0] a);
        if (a != 0 && a == al[0]) return {1'b1, remote_target_five};
        if (a != 0 && a == al[1]) return {1'b1, remote_target_six};
        if (a != 0 && a == al[2]) return {1'b1, remote_target_seven};
        return 8'h00;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_req <= '{1'b1, 1'b0, a, v};
        @(posedge sys_clk);
        reg_req <= '0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        reg_req <= '0;
        @(negedge sys_clk);
        `CHK("reg_rdata", e, reg_rdata)
        @(posedge sys_clk);
    endtask
    task automatic tx(input logic [6:0] a);
        txn <= '{1'b1, a};
        @(posedge sys_clk);
        txn <= '0;
        @(negedge sys_clk);
        `CHK("fwd", {1'b1, remap(a)}, fwd)
        @(posedge sys_clk);
    endtask
    task automatic end_sim;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        n_errors++;
        end_sim;
    end
    initial begin
        d = 8'($urandom(32'h8eb4));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int a = 8'h15; a < 8'h1c; a++) rd(8'(a), a == 8'h19 ? 8'h01 : 8'h00);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 4; i++) begin
            cond_req <= 2'(i);
            repeat (2) @(posedge sys_clk);
            rd(8'h1c, {arp_pkg::ARP_SILICON_REVISION, 2'b00, 2'(i)});
        end
        for (int i = 0; i < 3; i++) begin
            al[i] = 7'($urandom_range(1, 127));
            wr(8'h15 + 8'(i), {al[i], 1'b1});
            rd(8'h15 + 8'(i), {al[i], 1'b0});
        end
        for (int i = 0; i < 12; i++) tx(i < 3 ? al[i] : i == 3 ? 7'h0 : 7'($urandom));
        t = al[1];
        al[1] = 7'h0;
        wr(8'h16, 8'h00);
        tx(t);
        wr(8'h18, 8'h03);
        wr(8'h19, 8'h00);
        err_req <= 1'b1;
        repeat (5) @(posedge sys_clk);
        err_req <= 1'b0;
        rd(8'h1c, {arp_pkg::ARP_SILICON_REVISION, 2'b01, 2'b11});
        rd(8'h1a, 8'h03);
        d = 8'($urandom);
        wr(8'h1b, d);
        rd(8'h1b, d);
        wr(8'h1b, 8'h00);
        wr(8'h1a, 8'h00);
        rd(8'h1c, {arp_pkg::ARP_SILICON_REVISION, 2'b00, 2'b11});
        end_sim;
    end
endmodule
